// ==== shared/phm_pkg.sv ====
// Package of register map, field layout and carrier types for the PLL holdover control bank.
package phm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [9:0] PHM_ADDR_MISC = 10'h01D;
    localparam logic [9:0] PHM_ADDR_ZD = 10'h01E;
    localparam logic [9:0] PHM_ADDR_STAT = 10'h01F;

    // ------------------------------------------------------------------
    // Field positions of the misc control register
    // ------------------------------------------------------------------
    localparam int PHM_B_STATUS_EEPROM = 7;
    localparam int PHM_B_CRYSTAL = 6;
    localparam int PHM_B_DOUBLER = 5;
    localparam int PHM_B_STAT_FREEZE = 4;
    localparam int PHM_B_LOCK_CMP = 3;
    localparam int PHM_B_EXT_HOLD = 1;
    localparam int PHM_B_HOLD_EN = 0;

    // ------------------------------------------------------------------
    // Field positions of the zero delay register
    // ------------------------------------------------------------------
    localparam int PHM_B_FB_HI = 4;
    localparam int PHM_B_FB_LO = 3;
    localparam int PHM_B_ZD_EXT = 2;
    localparam int PHM_B_ZD_EN = 1;

    // ------------------------------------------------------------------
    // Reset values, writable masks and the status readback mask
    // ------------------------------------------------------------------
    localparam logic [7:0] PHM_MISC_RESET = 8'h80;
    localparam logic [7:0] PHM_MISC_MASK = 8'hFB;
    localparam logic [7:0] PHM_ZD_RESET = 8'h00;
    localparam logic [7:0] PHM_ZD_MASK = 8'h1E;
    localparam logic [7:0] PHM_STAT_MASK = 8'h7F;

    // ------------------------------------------------------------------
    // Pin synchroniser lanes and their idle levels
    // ------------------------------------------------------------------
    localparam int PHM_PIN_COUNT = 2;
    localparam int PHM_PIN_LOCK = 0;
    localparam int PHM_PIN_SYNC = 1;
    localparam logic [1:0] PHM_PIN_RESET = 2'h2;

    // Serial port request toward this bank.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } phm_req_type;

    // Controls handed to the analog and holdover logic.
    typedef struct packed {
        logic crystal_amp_en;
        logic doubler_en;
        logic lock_cmp_en;
        logic hold_en;
        logic ext_hold;
        logic ext_zero_delay;
        logic [1:0] fb_div_sel;
    } phm_ctrl_type;

endpackage

// ==== hdl/phm_status_hold.sv ====
// Status readback holding register that can be frozen by software.
`timescale 1ns/100ps
module phm_status_hold (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Live status and freeze control
    input wire logic [7:0] live_status,
    input wire logic freeze,
    // Held readback
    output logic [7:0] held_status
);

    // RL4 freeze stops update
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            held_status <= 8'h00;
        end else if (!freeze) begin
            held_status <= live_status & phm_pkg::PHM_STAT_MASK;
        end
    end

endmodule

// ==== hdl/phm_pll_holdover_misc_control.sv ====
// PLL holdover, crystal, doubler, status pin and zero delay control register bank.
//
// Operation
// RL1: Status-EEPROM bit overrides status selection field.
// RL2: Crystal amplifier enabled only when bit set.
// RL3: Reference doubler enabled only when bit set.
// RL4: Readback disable bit freezes PLL status register.
// RL5: Comparator off: lock-detect input treated high.
// RL6: Comparator on: lock-detect pin decides prior lock.
// RL7: External holdover bit hands control to sync.
// RL8: Internal holdover only when enable bit set.
// RL9: Feedback field selects channel divider zero..three.
// RL10: External zero delay needs enable and select.
`timescale 1ns/100ps
module phm_pll_holdover_misc_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Serial control port register access
    input wire phm_pkg::phm_req_type req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Status pin sources
    input wire logic status_eeprom,
    input wire logic status_selected,
    output logic status_pin,
    // Lock detect pin comparator and sync pin
    input wire logic lock_detect_pin_cmp,
    input wire logic sync_n_pin,
    // Live PLL status for readback
    input wire logic [7:0] pll_live_status,
    // Controls to the analog and holdover logic
    output phm_pkg::phm_ctrl_type ctrl,
    output logic lock_was_seen,
    output logic ext_hold_request
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] misc_q;
    logic [7:0] zd_q;
    logic [7:0] stat_held;
    logic [7:0] read_mux;
    // Synchroniser lanes: bit 0 carries the lock detect comparator, bit 1 the sync pin.
    logic [phm_pkg::PHM_PIN_COUNT-1:0] pin_raw;
    logic [phm_pkg::PHM_PIN_COUNT-1:0] pin_meta_q;
    logic [phm_pkg::PHM_PIN_COUNT-1:0] pin_sync_q;
    logic lock_sync;
    logic sync_sync;
    // Individual control flops, gathered into the carrier at the bottom.
    logic crystal_amp_q;
    logic doubler_q;
    logic lock_cmp_q;
    logic hold_en_q;
    logic ext_hold_q;
    logic ext_zero_delay_q;
    logic [1:0] fb_div_sel_q;
    // Write decodes.
    logic misc_wr;
    logic zd_wr;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign misc_wr = req.wr && (req.addr == phm_pkg::PHM_ADDR_MISC);
    assign zd_wr = req.wr && (req.addr == phm_pkg::PHM_ADDR_ZD);

    // Unused bits are masked on write so they always read back as zero.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            misc_q <= phm_pkg::PHM_MISC_RESET;
        end else if (misc_wr) begin
            misc_q <= req.wdata & phm_pkg::PHM_MISC_MASK;
        end
    end

    // Writes to the readback address or unmapped space change nothing.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            zd_q <= phm_pkg::PHM_ZD_RESET;
        end else if (zd_wr) begin
            zd_q <= req.wdata & phm_pkg::PHM_ZD_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero so software sees a defined value.
    always_comb begin
        case (req.addr)
            phm_pkg::PHM_ADDR_MISC: read_mux = misc_q;
            phm_pkg::PHM_ADDR_ZD: read_mux = zd_q;
            phm_pkg::PHM_ADDR_STAT: read_mux = stat_held;
            default: read_mux = 8'h00;
        endcase
    end

    // The strobe echo tells the port exactly which cycle carries the answer.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // Read data is held between reads so a slow port may pick it up late.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= read_mux;
        end
    end

    phm_status_hold u_status_hold (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .live_status(pll_live_status),
        .freeze(misc_q[phm_pkg::PHM_B_STAT_FREEZE]),
        .held_status(stat_held)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both pins are asynchronous; only the second stage may be read by logic.
    assign pin_raw = {sync_n_pin, lock_detect_pin_cmp};

    genvar g;
    generate
        for (g = 0; g < phm_pkg::PHM_PIN_COUNT; g++) begin : g_pin_sync
            // Reset to the idle level so no false request follows reset.
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    pin_meta_q[g] <= phm_pkg::PHM_PIN_RESET[g];
                    pin_sync_q[g] <= phm_pkg::PHM_PIN_RESET[g];
                end else begin
                    pin_meta_q[g] <= pin_raw[g];
                    pin_sync_q[g] <= pin_meta_q[g];
                end
            end
        end
    endgenerate

    assign lock_sync = pin_sync_q[phm_pkg::PHM_PIN_LOCK];
    assign sync_sync = pin_sync_q[phm_pkg::PHM_PIN_SYNC];

    // ------------------------------------------------------------------
    // Status pin
    // ------------------------------------------------------------------
    // The status sources are internal signals on this clock, so no synchroniser.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status_pin <= 1'b0;
        // RL1 eeprom status override
        end else if (misc_q[phm_pkg::PHM_B_STATUS_EEPROM]) begin
            status_pin <= status_eeprom;
        end else begin
            status_pin <= status_selected;
        end
    end

    // ------------------------------------------------------------------
    // Reference input enables
    // ------------------------------------------------------------------
    // RL2 crystal amplifier enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            crystal_amp_q <= 1'b0;
        end else begin
            crystal_amp_q <= misc_q[phm_pkg::PHM_B_CRYSTAL];
        end
    end

    // RL3 doubler enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            doubler_q <= 1'b0;
        end else begin
            doubler_q <= misc_q[phm_pkg::PHM_B_DOUBLER];
        end
    end

    // ------------------------------------------------------------------
    // Holdover controls
    // ------------------------------------------------------------------
    // RL6 comparator enable exported
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lock_cmp_q <= 1'b0;
        end else begin
            lock_cmp_q <= misc_q[phm_pkg::PHM_B_LOCK_CMP];
        end
    end

    // External holdover wins: a set enable bit is ignored while the sync pin rules.
    // RL8 internal holdover gating
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hold_en_q <= 1'b0;
        end else begin
            hold_en_q <= misc_q[phm_pkg::PHM_B_HOLD_EN] & ~misc_q[phm_pkg::PHM_B_EXT_HOLD];
        end
    end

    // RL7 external holdover select
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_hold_q <= 1'b0;
        end else begin
            ext_hold_q <= misc_q[phm_pkg::PHM_B_EXT_HOLD];
        end
    end

    // ------------------------------------------------------------------
    // Zero delay controls
    // ------------------------------------------------------------------
    // RL10 external zero delay
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_zero_delay_q <= 1'b0;
        end else begin
            ext_zero_delay_q <= zd_q[phm_pkg::PHM_B_ZD_EN] & zd_q[phm_pkg::PHM_B_ZD_EXT];
        end
    end

    // The divider choice is passed on even in internal mode; only its use is gated.
    // RL9 feedback divider select
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fb_div_sel_q <= 2'h0;
        end else begin
            fb_div_sel_q <= zd_q[phm_pkg::PHM_B_FB_HI:phm_pkg::PHM_B_FB_LO];
        end
    end

    // ------------------------------------------------------------------
    // Control carrier
    // ------------------------------------------------------------------
    assign ctrl = '{
        crystal_amp_en: crystal_amp_q,
        doubler_en: doubler_q,
        lock_cmp_en: lock_cmp_q,
        hold_en: hold_en_q,
        ext_hold: ext_hold_q,
        ext_zero_delay: ext_zero_delay_q,
        fb_div_sel: fb_div_sel_q
    };

    // ------------------------------------------------------------------
    // Lock detect qualifier
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lock_was_seen <= 1'b1;
        // RL6 comparator result used
        end else if (misc_q[phm_pkg::PHM_B_LOCK_CMP]) begin
            lock_was_seen <= lock_sync;
        // RL5 pin treated high
        end else begin
            lock_was_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // External holdover request
    // ------------------------------------------------------------------
    // Sync pin is active low; holdover is requested while it is held low and the external holdover bit is set.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_hold_request <= 1'b0;
        end else begin
            // RL7 sync pin commands holdover
            ext_hold_request <= misc_q[phm_pkg::PHM_B_EXT_HOLD] & ~sync_sync;
        end
    end

endmodule

// ==== bench/phm_props.sv ====
// Port level checks for the PLL holdover control bank.
`timescale 1ns/100ps
module phm_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register access
    input wire phm_pkg::phm_req_type req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Pins
    input wire logic status_eeprom,
    input wire logic status_selected,
    input wire logic status_pin,
    input wire logic lock_detect_pin_cmp,
    input wire logic sync_n_pin,
    input wire logic [7:0] pll_live_status,
    // Controls
    input wire phm_pkg::phm_ctrl_type ctrl,
    input wire logic lock_was_seen,
    input wire logic ext_hold_request
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic mw;
    logic zw;
    assign mw = req.wr && req.addr == phm_pkg::PHM_ADDR_MISC;
    assign zw = req.wr && req.addr == phm_pkg::PHM_ADDR_ZD;
    crystal_follows_a:
        assert property (mw |-> ##2 ctrl.crystal_amp_en == $past(req.wdata[6], 2))
        else $error("crystal enable mismatch");
    doubler_follows_a:
        assert property (mw |-> ##2 ctrl.doubler_en == $past(req.wdata[5], 2))
        else $error("doubler enable mismatch");
    hold_enable_a:
        assert property (mw |-> ##2 ctrl.hold_en == ($past(req.wdata[0], 2) && !$past(req.wdata[1], 2)))
        else $error("holdover enable mismatch");
    fb_select_a:
        assert property (zw |-> ##2 ctrl.fb_div_sel == $past(req.wdata[4:3], 2))
        else $error("feedback select mismatch");
    ext_zdelay_a:
        assert property (zw |-> ##2 ctrl.ext_zero_delay == ($past(req.wdata[2], 2) && $past(req.wdata[1], 2)))
        else $error("zero delay mode mismatch");
    lock_forced_a:
        assert property ((!ctrl.lock_cmp_en) [*2] |-> lock_was_seen)
        else $error("lock input not forced high");
    lock_pin_a:
        assert property ((ctrl.lock_cmp_en && $stable(lock_detect_pin_cmp)) [*4]
            |-> lock_was_seen == lock_detect_pin_cmp)
        else $error("lock input does not follow pin");
    ext_hold_a:
        assert property ((ctrl.ext_hold && $stable(sync_n_pin)) [*4] |-> ext_hold_request == !sync_n_pin)
        else $error("external hold does not follow sync");
    read_answer_a:
        assert property (req.rd |=> rvalid)
        else $error("read not answered");
endmodule
bind phm_pll_holdover_misc_control phm_props u_props (.*);

// ==== bench/tb_phm_pll_holdover_misc_control.sv ====
// Self-checking bench for the PLL holdover control bank.
`timescale 1ns/100ps
module tb_phm_pll_holdover_misc_control;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    phm_pkg::phm_req_type req = '0;
    logic status_eeprom = 1'b0;
    logic status_selected = 1'b1;
    logic lock_detect_pin_cmp = 1'b1;
    logic sync_n_pin = 1'b1;
    logic [7:0] pll_live_status = 8'hB5;
    logic [7:0] rdata;
    logic rvalid;
    logic status_pin;
    phm_pkg::phm_ctrl_type ctrl;
    logic lock_was_seen;
    logic ext_hold_request;
    int n_mismatch = 0;
    int samples_checked = 0;
    phm_pll_holdover_misc_control DUT (.*);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The extra two cycles let the registered controls settle before a check.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req.wr = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge sys_clk);
        req.rd = 1'b0;
        chk("rvalid", {7'h00, rvalid}, 8'h01);
        chk("rdata", rdata, exp);
    endtask
    task automatic final_report;
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_misc;
        rd(phm_pkg::PHM_ADDR_MISC, 8'h80);
        chk("lock_seen", lock_was_seen, 8'h01);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h61);
        chk("crystal", ctrl.crystal_amp_en, 8'h01);
        chk("doubler", ctrl.doubler_en, 8'h01);
        chk("hold_en", ctrl.hold_en, 8'h01);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h0A);
        sync_n_pin = 1'b0;
        lock_detect_pin_cmp = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("hold_en", ctrl.hold_en, 8'h00);
        chk("ext_req", ext_hold_request, 8'h01);
        chk("lock_seen", lock_was_seen, 8'h00);
        wr(phm_pkg::PHM_ADDR_MISC, 8'hFF);
        rd(phm_pkg::PHM_ADDR_MISC, 8'hFB);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h00);
        chk("lock_seen", lock_was_seen, 8'h01);
        chk("doubler", ctrl.doubler_en, 8'h00);
        sync_n_pin = 1'b1;
    endtask
    task automatic t_zd;
        rd(phm_pkg::PHM_ADDR_ZD, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(phm_pkg::PHM_ADDR_ZD, {3'h0, i[1:0], 3'h6});
            chk("fb_sel", {6'h00, ctrl.fb_div_sel}, i[7:0]);
            chk("ext_zd", ctrl.ext_zero_delay, 8'h01);
        end
        wr(phm_pkg::PHM_ADDR_ZD, 8'hFC);
        chk("ext_zd", ctrl.ext_zero_delay, 8'h00);
        rd(phm_pkg::PHM_ADDR_ZD, 8'h1C);
    endtask
    task automatic t_pin_stat;
        status_eeprom = 1'b1;
        status_selected = 1'b0;
        wr(phm_pkg::PHM_ADDR_MISC, 8'h80);
        chk("status_pin", status_pin, 8'h01);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h00);
        chk("status_pin", status_pin, 8'h00);
        rd(phm_pkg::PHM_ADDR_STAT, 8'h35);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h10);
        pll_live_status = 8'h2A;
        rd(phm_pkg::PHM_ADDR_STAT, 8'h35);
        rd(10'h020, 8'h00);
        wr(phm_pkg::PHM_ADDR_MISC, 8'h00);
        rd(phm_pkg::PHM_ADDR_STAT, 8'h2A);
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        t_misc;
        t_zd;
        t_pin_stat;
        final_report;
    end
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
endmodule
